// ### rtl/pss_pkg.sv
// Package for the port register access stall timing block
//
// Overview of operation
// - Port register operands take longer than others
// - On-chip code and data: baseline only
// - On-chip code, port operand: add 1/2
// - External, no wait, short strobe: 2/4
// - External, one wait, short strobe: 3/6
// - External, one wait, long strobe: 4/8
// - Extra added on mode's baseline count
// - Single-penalty class uses 1,2,3,4 pattern
// - Double-penalty class uses 2,4,6,8 pattern
// - External fetch, wait, long strobe lengthen execution
package pss_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [3:0] PSS_CTRL_OFS = 4'h0;
    localparam logic [3:0] PSS_STAT_OFS = 4'h4;
    localparam logic [3:0] PSS_PCNT_OFS = 4'h8;

    // Control register field positions
    localparam int PSS_CTRL_SRC_MODE = 0;
    localparam int PSS_CTRL_EXT_FETCH = 1;
    localparam int PSS_CTRL_WAIT_ONE = 2;
    localparam int PSS_CTRL_ALE_EXT = 3;

    // Status register field positions
    localparam int PSS_STAT_EXTRA_LSB = 0;
    localparam int PSS_STAT_TOTAL_LSB = 8;
    localparam int PSS_STAT_BUSY = 16;

    // Values after reset
    localparam logic [3:0] PSS_CTRL_RST = 4'h0;
    localparam logic [15:0] PSS_PCNT_RST = 16'h0000;

    // Added states for a single penalty, per condition
    localparam logic [3:0] PSS_ADD_ONCHIP = 4'h1;
    localparam logic [3:0] PSS_ADD_EXT_BASE = 4'h2;

    // Shortest instruction, in state times
    localparam logic [4:0] PSS_MIN_STATES = 5'h01;

    // Instruction penalty class from the sequencer
    typedef enum logic [1:0] {
        PSS_PEN_NONE,
        PSS_PEN_SINGLE,
        PSS_PEN_DOUBLE
    } pss_pclass_t;

    // Bus and strobe configuration held in the control register
    typedef struct packed {
        logic ale_ext;
        logic wait_one;
        logic ext_fetch;
        logic src_mode;
    } pss_cfg_t;

    // One instruction handed over by the sequencer
    typedef struct packed {
        logic [3:0] base_bin;
        logic [3:0] base_src;
        pss_pclass_t pclass;
        logic is_sfr;
        logic [7:0] opnd_addr;
    } pss_req_t;

endpackage : pss_pkg

// ### rtl/pss_stall_ctrl.sv
// Stall timing controller for instructions that touch the I/O port registers
`timescale 1ns/1ps
module pss_stall_ctrl #(
    // Special function register addresses of the four port registers (arbitrary)
    parameter logic [7:0] PORT0_ADDR = 8'hC0,
    parameter logic [7:0] PORT1_ADDR = 8'hC1,
    parameter logic [7:0] PORT2_ADDR = 8'hC2,
    parameter logic [7:0] PORT3_ADDR = 8'hC3
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Instruction sequencer
    input wire logic instr_start,
    input wire pss_pkg::pss_req_t instr_req,
    output logic instr_busy,
    output logic instr_done,
    output logic [4:0] instr_states
);

    // Sequencer state
    typedef enum logic {
        PSS_IDLE,
        PSS_RUN
    } pss_state_t;

    pss_state_t state_q;            // Idle or counting states
    logic [4:0] cnt_q;              // States left in current instruction
    logic [4:0] total_q;            // States of the last instruction
    logic [3:0] extra_q;            // Extra states of the last instruction
    logic [15:0] pcnt_q;            // Instructions that drew a port penalty
    pss_pkg::pss_cfg_t cfg_q;       // Fetch source, wait, strobe, mode
    logic ack_q;                    // Bus acknowledge
    logic [31:0] rdat_q;            // Bus read data
    logic port_hit;                 // Operand is one of the port registers
    logic [3:0] extra_d;            // Extra states for a new instruction
    logic [4:0] base_d;             // Baseline for the current mode
    logic [4:0] total_d;            // Baseline plus extra
    logic take;                     // New instruction accepted
    logic bus_req;                  // Bus cycle awaiting acknowledge

    // Extra states per penalty class and bus setting
    function automatic logic [3:0] pss_extra(input pss_pkg::pss_pclass_t pc,
                                             input pss_pkg::pss_cfg_t cfg);
        logic [3:0] single;
        single = pss_pkg::PSS_ADD_ONCHIP;
        if (cfg.ext_fetch) begin
            single = pss_pkg::PSS_ADD_EXT_BASE + {3'h0, cfg.wait_one} + {3'h0, cfg.ale_ext};
        end
        case (pc)
            pss_pkg::PSS_PEN_SINGLE: pss_extra = single;
            pss_pkg::PSS_PEN_DOUBLE: pss_extra = {single[2:0], 1'b0};
            default: pss_extra = 4'h0;
        endcase
    endfunction : pss_extra

    // Operand address decode against the port registers
    always_comb begin
        port_hit = instr_req.is_sfr &&
                   (instr_req.opnd_addr == PORT0_ADDR || instr_req.opnd_addr == PORT1_ADDR ||
                    instr_req.opnd_addr == PORT2_ADDR || instr_req.opnd_addr == PORT3_ADDR);
    end

    // Stall selection and total state count
    always_comb begin
        base_d = {1'b0, cfg_q.src_mode ? instr_req.base_src : instr_req.base_bin};
        if (base_d < pss_pkg::PSS_MIN_STATES) begin
            base_d = pss_pkg::PSS_MIN_STATES;
        end
        extra_d = port_hit ? pss_extra(instr_req.pclass, cfg_q) : 4'h0;
        total_d = base_d + {1'b0, extra_d};
    end

    // A new instruction is only taken while idle; starts while busy are ignored
    assign take = instr_start && (state_q == PSS_IDLE);
    assign instr_busy = (state_q == PSS_RUN);

    // State counter, one count per state time
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= PSS_IDLE;
            cnt_q <= 5'h00;
        end else begin
            case (state_q)
                // Load the whole length at acceptance
                PSS_IDLE: begin
                    if (take) begin
                        state_q <= PSS_RUN;
                        cnt_q <= total_d;
                    end
                end
                // Count down, leave after the last state
                PSS_RUN: begin
                    cnt_q <= cnt_q - 5'h01;
                    if (cnt_q == 5'h01) begin
                        state_q <= PSS_IDLE;
                    end
                end
                default: begin
                    state_q <= PSS_IDLE;
                    cnt_q <= 5'h00;
                end
            endcase
        end
    end

    // Completion pulse in the last state of the instruction
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            instr_done <= 1'b0;
        end else begin
            instr_done <= (state_q == PSS_RUN) && (cnt_q == 5'h02) ||
                          take && (total_d == 5'h01);
        end
    end

    // Result capture for status and sequencer
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            total_q <= 5'h00;
            extra_q <= 4'h0;
        end else if (take) begin
            total_q <= total_d;
            extra_q <= extra_d;
        end
    end
    assign instr_states = total_q;

    // Count of penalised instructions, wraps; cleared by a write to the count offset
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pcnt_q <= pss_pkg::PSS_PCNT_RST;
        end else if (take && (extra_d != 4'h0)) begin
            // Clear and event in the same cycle leave a count of one
            pcnt_q <= (bus_req && wb_we_i && wb_adr_i == pss_pkg::PSS_PCNT_OFS) ?
                      16'h0001 : pcnt_q + 16'h0001;
        end else if (bus_req && wb_we_i && wb_adr_i == pss_pkg::PSS_PCNT_OFS) begin
            pcnt_q <= pss_pkg::PSS_PCNT_RST;
        end
    end

    // Bus request pending while no acknowledge given yet
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;

    // Acknowledge one cycle after the strobe, dropped the cycle after
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req;
        end
    end
    assign wb_ack_o = ack_q;

    // Control register write; setting changes apply to the next accepted instruction
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q <= pss_pkg::PSS_CTRL_RST;
        end else if (bus_req && wb_we_i && wb_sel_i[0] &&
                     wb_adr_i == pss_pkg::PSS_CTRL_OFS) begin
            cfg_q <= wb_dat_i[3:0];
        end
    end

    // Read data, registered; unmapped offsets read zero
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdat_q <= 32'h0000_0000;
        end else if (bus_req) begin
            rdat_q <= 32'h0000_0000;
            case (wb_adr_i)
                pss_pkg::PSS_CTRL_OFS: rdat_q[3:0] <= cfg_q;
                pss_pkg::PSS_STAT_OFS: begin
                    rdat_q[pss_pkg::PSS_STAT_EXTRA_LSB +: 4] <= extra_q;
                    rdat_q[pss_pkg::PSS_STAT_TOTAL_LSB +: 5] <= total_q;
                    rdat_q[pss_pkg::PSS_STAT_BUSY] <= instr_busy;
                end
                pss_pkg::PSS_PCNT_OFS: rdat_q[15:0] <= pcnt_q;
                default: rdat_q <= 32'h0000_0000;
            endcase
        end
    end
    assign wb_dat_o = rdat_q;

endmodule : pss_stall_ctrl

// ### tb/pss_props.sv
// Checker for the sequencer side of the port register stall controller
`timescale 1ns/1ps
module pss_props #(
    parameter logic [7:0] P0 = 8'hC0,
    parameter logic [7:0] P1 = 8'hC1,
    parameter logic [7:0] P2 = 8'hC2,
    parameter logic [7:0] P3 = 8'hC3
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Sequencer handshake
    input wire logic instr_start,
    input wire pss_pkg::pss_req_t instr_req,
    input wire logic instr_busy,
    input wire logic instr_done,
    input wire logic [4:0] instr_states
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Mode bit is not visible here, so bound by both baselines
    wire logic [3:0] bb = instr_req.base_bin;
    wire logic [3:0] bs = instr_req.base_src;
    wire logic [4:0] lo = (bb < bs) ? {1'b0, bb} : {1'b0, bs};
    wire logic [4:0] hi = (bb < bs) ? {1'b0, bs} : {1'b0, bb};
    wire logic hit = instr_req.is_sfr && instr_req.pclass != pss_pkg::PSS_PEN_NONE
        && instr_req.opnd_addr inside {P0, P1, P2, P3};
    wire logic one = instr_req.pclass == pss_pkg::PSS_PEN_SINGLE;
    // Busy cycles already spent in the current instruction
    logic [4:0] cnt_q;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= instr_busy ? cnt_q + 5'h01 : 5'h00;
        end
    end
    // Accepted hand-over with nonzero baselines
    sequence s_take;
        instr_start && !instr_busy && bb != 4'h0 && bs != 4'h0;
    endsequence
    // Bounds come from the hand-over edge; the request may change right after it
    a_no_port_base: assert property (s_take ##0 !hit |=>
        instr_states >= $past(lo) && instr_states <= $past(hi))
        else $error("extra states without a port operand");
    a_single_range: assert property (s_take ##0 (hit && one) |=>
        instr_states >= $past(lo) + 5'h01 && instr_states <= $past(hi) + 5'h04)
        else $error("single extra");
    a_double_range: assert property (s_take ##0 (hit && !one) |=>
        instr_states >= $past(lo) + 5'h02 && instr_states <= $past(hi) + 5'h08)
        else $error("double extra");
    a_port_longer: assert property (s_take ##0 hit |=> instr_states > $past(lo))
        else $error("port operand not lengthened");
    a_busy_on_take: assert property (instr_start && !instr_busy |=> instr_busy)
        else $error("busy missing after take");
    a_busy_length: assert property (instr_done |-> instr_busy && cnt_q + 5'h01 == instr_states)
        else $error("busy length differs from total");
    a_done_ends: assert property (instr_done |=> !instr_busy)
        else $error("busy after done");
    a_states_hold: assert property (instr_busy && !instr_done |=> $stable(instr_states))
        else $error("total changed while busy");
endmodule : pss_props
bind pss_stall_ctrl pss_props #(.P0(PORT0_ADDR), .P1(PORT1_ADDR), .P2(PORT2_ADDR),
    .P3(PORT3_ADDR)) u_props (.ref_clk, .reset_n, .instr_start, .instr_req, .instr_busy,
    .instr_done, .instr_states);

// ### tb/pss_seq_model.sv
// Instruction sequencer model feeding the stall controller
`timescale 1ns/1ps
module pss_seq_model (
    // Clock
    input wire logic ref_clk,
    // Controller status
    input wire logic instr_busy,
    input wire logic instr_done,
    // Requests
    output logic instr_start,
    output pss_pkg::pss_req_t instr_req
);
    initial begin
        instr_start = 1'b0;
        instr_req = '0;
    end
    // One hand-over, then wait for the last state under a bound
    task automatic issue(input pss_pkg::pss_req_t r, output logic hung);
        int n;
        @(posedge ref_clk);
        instr_start <= 1'b1;
        instr_req <= r;
        @(posedge ref_clk);
        instr_start <= 1'b0;
        // Scrambled after the take so late sampling shows up
        instr_req <= ~r;
        n = 0;
        do @(posedge ref_clk); while (instr_done !== 1'b1 && ++n < 40);
        hung = (n >= 40);
    endtask : issue
endmodule : pss_seq_model

// ### tb/testbench.sv
// Self-checking bench for the port register stall controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin error_cnt++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
    // Clock, reset and bus drive
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, busy, done, start, hung;
    logic [3:0] adr = 4'h0, sel = 4'hF;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [4:0] states;
    pss_pkg::pss_req_t req;
    int error_cnt = 0, compares = 0;
    logic [3:0] cfg [4] = '{4'h0, 4'h2, 4'h6, 4'hE};
    initial forever #50 ref_clk = ~ref_clk;
    pss_stall_ctrl uut (.ref_clk, .reset_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .instr_start(start), .instr_req(req), .instr_busy(busy), .instr_done(done),
        .instr_states(states));
    pss_seq_model seq (.ref_clk, .instr_busy(busy), .instr_done(done), .instr_start(start),
        .instr_req(req));
    // Classic single cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int n;
        @(posedge ref_clk);
        {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
        n = 0;
        do @(posedge ref_clk); while (ack !== 1'b1 && ++n < 50);
        r = rdat;
        {cyc, stb} <= 2'h0;
        `CHK("bus ack", 1'b0, n >= 50)
        if (n >= 50) report_and_stop();
    endtask : wb
    // Issue one instruction and compare its total
    task automatic run(input pss_pkg::pss_req_t r, input logic [4:0] ex);
        seq.issue(r, hung);
        `CHK("hang", 1'b0, hung)
        if (hung) report_and_stop();
        `CHK("states", ex, states)
    endtask : run
    task automatic report_and_stop();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        pss_pkg::pss_req_t r;
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        wb(1'b0, 4'hC, 32'h0, q); `CHK("unmapped", 32'h0, q)
        for (int k = 0; k < 8; k++) begin
            wb(1'b1, pss_pkg::PSS_CTRL_OFS, {28'h0, cfg[k / 2] | 4'(k % 2)}, q);
            for (int c = 0; c < 3; c++) begin
                r = {4'h3, 4'h2, pss_pkg::pss_pclass_t'(c), 1'b1, 8'hC0 + 8'(k / 2)};
                run(r, 5'(3 - k % 2 + c * (k / 2 + 1)));
            end
        end
        // Last loop step was a double penalty in the fourth condition: extra 8, total 10
        wb(1'b0, pss_pkg::PSS_STAT_OFS, 32'h0, q); `CHK("stat port", 32'hA08, q)
        wb(1'b1, pss_pkg::PSS_CTRL_OFS, 32'h0, q);
        sel <= 4'hE;
        wb(1'b1, pss_pkg::PSS_CTRL_OFS, 32'hF, q);
        sel <= 4'hF;
        wb(1'b0, pss_pkg::PSS_CTRL_OFS, 32'h0, q); `CHK("ctrl", 32'h0, q)
        run({4'h3, 4'h2, pss_pkg::PSS_PEN_DOUBLE, 1'b0, 8'hC1}, 5'h03);
        run({4'h3, 4'h2, pss_pkg::PSS_PEN_DOUBLE, 1'b1, 8'hC4}, 5'h03);
        wb(1'b0, pss_pkg::PSS_STAT_OFS, 32'h0, q); `CHK("stat", 32'h300, q)
        wb(1'b0, pss_pkg::PSS_PCNT_OFS, 32'h0, q); `CHK("pcnt", 32'h10, q)
        wb(1'b1, pss_pkg::PSS_PCNT_OFS, 32'h0, q);
        wb(1'b0, pss_pkg::PSS_PCNT_OFS, 32'h0, q); `CHK("pcnt clr", 32'h0, q)
        report_and_stop();
    end
endmodule : testbench
